// ==== hdl/exp_hold_pkg.sv ====
// Package: register map, field positions and reset values for the expansion hold controller
package exp_hold_pkg;
    localparam int          NUM_BASES       = 4;
    localparam int          SLOTS_PER_BASE  = 8;
    localparam int          NUM_MODULES     = 32;
    localparam int          ADDR_W          = 12;
    // Register byte addresses
    localparam logic [11:0] OFF_HOLD12      = 12'h000;
    localparam logic [11:0] OFF_HOLD34      = 12'h004;
    localparam logic [11:0] OFF_CTRL        = 12'h008;
    localparam logic [11:0] OFF_STATUS      = 12'h00c;
    localparam logic [11:0] OFF_INT_STAT    = 12'h010;
    localparam logic [11:0] OFF_INT_MASK    = 12'h014;
    localparam logic [11:0] OFF_CFG_REF     = 12'h018;
    localparam logic [11:0] OFF_MAN_MAP     = 12'h01c;
    localparam logic [11:0] OFF_ADDR_MAP    = 12'h020;
    // Control fields
    localparam int          CTRL_RUN_REQ    = 0;
    localparam int          CTRL_CHK_EN     = 1;
    localparam int          CTRL_MAN_ADDR   = 2;
    localparam int          CTRL_FAIL_CLR   = 3;
    // Status fields
    localparam int          ST_RUN_BIT      = 0;
    localparam int          ST_PWRUP_BIT    = 1;
    localparam int          ST_FAIL_LSB     = 4;
    localparam int          ST_PRES_LSB     = 8;
    // Interrupt events
    localparam int          EV_COMM_FAIL    = 0;
    localparam int          EV_CFG_REFUSE   = 1;
    // Reset values
    localparam logic [15:0] HOLD_RESET      = 16'h0000;
    localparam logic [3:0]  CFG_REF_RESET   = 4'hf;
    localparam logic [7:0]  MAN_MAP_RESET   = 8'he4;
    localparam logic [1:0]  INT_MASK_RESET  = 2'h0;

    typedef enum logic [1:0] {
        ST_PWRUP,
        ST_STOP,
        ST_RUN
    } run_state_t;
endpackage

// ==== hdl/exp_hold_ctrl.sv ====
// Expansion base output hold, run/stop and I/O configuration check controller
// What this block does
// R1 - Comm failure of any base present at power-up forces run to stop
// R2 - Hold bit set keeps module outputs unchanged
// R3 - Hold bit clear drives module outputs off
// R4 - Two hold words, eight slot bits per base
// R5 - Hold choice applies per module, not base
// R6 - Config check refuses run on changed configuration
// R7 - Auto addressing compacts present bases, run allowed
// R8 - Manual addressing keeps user map, check usable
// R9 - Failure response in same scan as detection
`timescale 1ns/1ps
module exp_hold_ctrl
    import exp_hold_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  base_present,
    input  wire logic [3:0]  base_comm_ok,
    input  wire logic [31:0] out_image,
    output logic      [31:0] module_out,
    output logic      [7:0]  base_addr_map,
    output logic             run_mode,
    output logic             irq
);

    typedef struct packed {
        run_state_t  state;
        logic [15:0] hold12;
        logic [15:0] hold34;
        logic        run_req;
        logic        chk_en;
        logic        man_addr;
        logic [3:0]  pwr_present;
        logic [3:0]  cfg_ref;
        logic [7:0]  man_map;
        logic [3:0]  fail;
        logic [1:0]  int_st;
        logic [1:0]  int_mask;
        logic [31:0] outs;
        logic [7:0]  addr_map;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        run;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Number of present bases below a given base number
    function automatic logic [1:0] bases_below(input logic [3:0] pres, input int b);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < NUM_BASES; i++) begin
            if (i < b && pres[i]) begin
                n = n + 3'h1;
            end
        end
        return n[1:0];
    endfunction

    // Register address hit check
    function automatic logic is_mapped(input logic [11:0] a);
        return a == OFF_HOLD12 || a == OFF_HOLD34 || a == OFF_CTRL || a == OFF_STATUS
            || a == OFF_INT_STAT || a == OFF_INT_MASK || a == OFF_CFG_REF
            || a == OFF_MAN_MAP || a == OFF_ADDR_MAP;
    endfunction

    logic        setup_ph;
    logic        wr_en;
    logic [31:0] hold_all;
    logic [3:0]  fail_now;
    logic        cfg_changed;
    logic [1:0]  events;

    always_comb begin
        s_d         = s_q;
        setup_ph    = psel && !penable;
        wr_en       = psel && penable && s_q.pready && pwrite;
        hold_all    = {s_q.hold34, s_q.hold12};
        // Only bases seen at power-up are watched; absent ones carry no outputs
        fail_now    = (s_q.state == ST_RUN) ? (s_q.pwr_present & ~base_comm_ok) : 4'h0;
        cfg_changed = s_q.chk_en && (s_q.pwr_present != s_q.cfg_ref); // R6 R8
        events      = 2'h0;

        // Register writes
        if (wr_en) begin
            unique case (paddr)
                OFF_HOLD12:   s_d.hold12 = pwdata[15:0]; // R4
                OFF_HOLD34:   s_d.hold34 = pwdata[15:0]; // R4
                OFF_CTRL: begin
                    s_d.run_req  = pwdata[CTRL_RUN_REQ];
                    s_d.chk_en   = pwdata[CTRL_CHK_EN];
                    s_d.man_addr = pwdata[CTRL_MAN_ADDR];
                    if (pwdata[CTRL_FAIL_CLR]) begin
                        s_d.fail = 4'h0;
                    end
                end
                OFF_INT_STAT: s_d.int_st = s_q.int_st & ~pwdata[1:0];
                OFF_INT_MASK: s_d.int_mask = pwdata[1:0];
                OFF_CFG_REF:  s_d.cfg_ref = pwdata[3:0];
                OFF_MAN_MAP:  s_d.man_map = pwdata[7:0];
                default: ;
            endcase
        end

        // Failure latch; a new failure wins over a clear in the same cycle
        s_d.fail = s_d.fail | fail_now;

        // Run/stop sequencing
        unique case (s_q.state)
            ST_PWRUP: begin
                // Presence caught once after reset release
                s_d.pwr_present = base_present;
                s_d.state       = ST_STOP;
            end
            ST_STOP: begin
                if (s_q.run_req && s_q.fail == 4'h0) begin
                    if (cfg_changed) begin
                        s_d.run_req           = 1'b0; // R6
                        events[EV_CFG_REFUSE] = 1'b1;
                    end else begin
                        s_d.state = ST_RUN; // R7
                    end
                end
            end
            ST_RUN: begin
                if (fail_now != 4'h0) begin
                    s_d.state            = ST_STOP; // R1 R9
                    s_d.run_req          = 1'b0;
                    events[EV_COMM_FAIL] = 1'b1;
                end
            end
            default: s_d.state = ST_STOP;
        endcase

        // Run flag kept in a flop so run_mode has no decode behind it
        s_d.run = s_d.state == ST_RUN;

        // Interrupt status, set wins over clear
        s_d.int_st = s_d.int_st | events;
        s_d.irq    = |(s_d.int_st & s_q.int_mask);

        // Per-module output response, decided in the failing cycle itself
        for (int b = 0; b < NUM_BASES; b++) begin
            for (int m = 0; m < SLOTS_PER_BASE; m++) begin
                if (s_d.fail[b]) begin
                    // Hold bits picked per slot, so one base may mix responses
                    s_d.outs[b*8+m] = hold_all[b*8+m] ? s_q.outs[b*8+m] : 1'b0; // R2 R3 R5 R9
                end else begin
                    s_d.outs[b*8+m] = out_image[b*8+m];
                end
            end
        end

        // Base address order; manual map is never rewritten by the block
        for (int b = 0; b < NUM_BASES; b++) begin
            if (s_q.man_addr) begin
                s_d.addr_map[b*2 +: 2] = s_q.man_map[b*2 +: 2]; // R8
            end else begin
                s_d.addr_map[b*2 +: 2] = bases_below(s_q.pwr_present, b); // R7
            end
        end

        // APB answer: ready in the access phase, one wait-free cycle
        s_d.pready  = setup_ph;
        s_d.pslverr = setup_ph && !is_mapped(paddr);
        s_d.prdata  = 32'h0000_0000;
        if (setup_ph && !pwrite) begin
            unique case (paddr)
                OFF_HOLD12:   s_d.prdata = {16'h0000, s_q.hold12};
                OFF_HOLD34:   s_d.prdata = {16'h0000, s_q.hold34};
                OFF_CTRL:     s_d.prdata = {28'h0000000, 1'b0, s_q.man_addr, s_q.chk_en, s_q.run_req};
                OFF_STATUS: begin
                    s_d.prdata[ST_RUN_BIT]            = s_q.state == ST_RUN;
                    s_d.prdata[ST_PWRUP_BIT]          = cfg_changed;
                    s_d.prdata[ST_FAIL_LSB +: 4]      = s_q.fail;
                    s_d.prdata[ST_PRES_LSB +: 4]      = s_q.pwr_present;
                end
                OFF_INT_STAT: s_d.prdata = {30'h0, s_q.int_st};
                OFF_INT_MASK: s_d.prdata = {30'h0, s_q.int_mask};
                OFF_CFG_REF:  s_d.prdata = {28'h0000000, s_q.cfg_ref};
                OFF_MAN_MAP:  s_d.prdata = {24'h000000, s_q.man_map};
                OFF_ADDR_MAP: s_d.prdata = {24'h000000, s_q.addr_map};
                default:      s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // State register; outputs off and in ST_PWRUP after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q.state       <= ST_PWRUP;
            s_q.hold12      <= HOLD_RESET;
            s_q.hold34      <= HOLD_RESET;
            s_q.run_req     <= 1'b0;
            s_q.chk_en      <= 1'b0;
            s_q.man_addr    <= 1'b0;
            s_q.pwr_present <= 4'h0;
            s_q.cfg_ref     <= CFG_REF_RESET;
            s_q.man_map     <= MAN_MAP_RESET;
            s_q.fail        <= 4'h0;
            s_q.int_st      <= 2'h0;
            s_q.int_mask    <= INT_MASK_RESET;
            s_q.outs        <= 32'h0000_0000;
            s_q.addr_map    <= 8'h00;
            s_q.prdata      <= 32'h0000_0000;
            s_q.pready      <= 1'b0;
            s_q.pslverr     <= 1'b0;
            s_q.irq         <= 1'b0;
            s_q.run         <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata        = s_q.prdata;
    assign pready        = s_q.pready;
    assign pslverr       = s_q.pslverr;
    assign module_out    = s_q.outs;
    assign base_addr_map = s_q.addr_map;
    assign run_mode      = s_q.run;
    assign irq           = s_q.irq;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_fail_stops_run: assert property (fail_now != 4'h0 |=> s_q.state == ST_STOP) // R1
        else $error("comm failure did not stop run");
    a_held_output: assert property (s_d.fail[0] && hold_all[0] |=> module_out[0] == $past(module_out[0])) // R2
        else $error("held output changed");
    a_off_output: assert property (s_d.fail[1] && !hold_all[8] |=> !module_out[8]) // R3
        else $error("unheld output not off");
    a_hold_word_map: assert property (wr_en && paddr == OFF_HOLD34 |=> hold_all[31:16] == $past(pwdata[15:0])) // R4
        else $error("hold word map wrong");
    a_mixed_slots: assert property (s_d.fail[2] && hold_all[16] && !hold_all[17]
                                    |=> module_out[16] == $past(module_out[16]) && !module_out[17]) // R5
        else $error("per-slot response wrong");
    a_cfg_refuse: assert property (s_q.state == ST_STOP && cfg_changed |=> s_q.state != ST_RUN) // R6
        else $error("run entered with changed config");
    a_auto_compact: assert property (!s_q.man_addr && !s_q.pwr_present[0] && s_q.pwr_present[1]
                                     |=> base_addr_map[3:2] == 2'h0) // R7
        else $error("auto address not shifted");
    a_manual_map: assert property (s_q.man_addr |=> base_addr_map == $past(s_q.man_map)) // R8
        else $error("manual map not kept");
    a_same_scan: assert property (fail_now[3] && !hold_all[31] |=> !module_out[31] && !run_mode) // R9
        else $error("failure response late");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready || (psel && !penable))
        else $error("apb ready timing wrong");

    // Stop side: a latched failure or a withdrawn request keeps the block out of run
    a_run_needs_clean: assert property (s_q.state == ST_STOP && s_q.fail != 4'h0 |=> s_q.state != ST_RUN) // R1
        else $error("run entered with failure latched");
    a_stop_no_req: assert property (s_q.state == ST_STOP && !s_q.run_req |=> s_q.state != ST_RUN) // R1
        else $error("run entered without request");
    a_fail_latch: assert property (fail_now != 4'h0 |=> (s_q.fail & $past(fail_now)) == $past(fail_now)) // R1
        else $error("failure not latched");
    a_int_set_wins: assert property (events[EV_COMM_FAIL] |=> s_q.int_st[EV_COMM_FAIL]) // R1
        else $error("failure event lost");

    // Output side: healthy bases follow the image, failed ones hold or drop per slot
    a_live_base: assert property (s_q.state != ST_PWRUP && !s_d.fail[0]
                                  |=> module_out[7:0] == $past(out_image[7:0])) // R5
        else $error("healthy base not following image");
    a_live_base_top: assert property (s_q.state != ST_PWRUP && !s_d.fail[3]
                                      |=> module_out[31:24] == $past(out_image[31:24])) // R5
        else $error("healthy top base not following image");
    a_held_base_two: assert property (s_d.fail[1] && hold_all[15] |=> module_out[15] == $past(module_out[15])) // R2
        else $error("held output of second base changed");
    a_off_base_top: assert property (s_d.fail[3] && !hold_all[24] |=> !module_out[24]) // R3
        else $error("unheld output of top base not off");
    a_hold_low_map: assert property (wr_en && paddr == OFF_HOLD12 |=> hold_all[15:0] == $past(pwdata[15:0])) // R4
        else $error("low hold word map wrong");

    // Start side: power-up capture, refusal and unchecked entry
    a_pwrup_capture: assert property (resetn && s_q.state == ST_PWRUP
                                      |=> s_q.pwr_present == $past(base_present) && s_q.state == ST_STOP) // R6
        else $error("power-up presence not captured");
    a_refuse_clears_req: assert property (s_q.state == ST_STOP && s_q.run_req && s_q.fail == 4'h0 && cfg_changed
                                          |=> !s_q.run_req) // R6
        else $error("refused run request not withdrawn");
    a_auto_run: assert property (s_q.state == ST_STOP && s_q.run_req && s_q.fail == 4'h0 && !s_q.chk_en
                                 |=> run_mode) // R7
        else $error("unchecked run request not honoured");

    // Bus side: one-cycle answer, error only with ready, idle read data zero
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (setup_ph && !is_mapped(paddr) |=> pready && pslverr)
        else $error("unmapped access without error");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_prdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access cycle");

    c_run_entry:  cover property (s_q.state == ST_STOP ##1 s_q.state == ST_RUN);
    c_comm_fail:  cover property (s_q.state == ST_RUN && fail_now != 4'h0);
    c_cfg_refuse: cover property (events[EV_CFG_REFUSE]);
    c_irq_raise:  cover property (!irq ##1 irq);
    c_held_fail:  cover property (s_d.fail != 4'h0 && hold_all != 32'h0000_0000);
endmodule

// ==== tb/exp_base_model.sv ====
// Behavioural model of the expansion bases on the daisy chain
`timescale 1ns/1ps
module exp_base_model (
    input  wire logic       clk,
    input  wire logic [3:0] present_cfg,
    input  wire logic [3:0] drop,
    input  wire logic       slow,
    output logic      [3:0] base_present,
    output logic      [3:0] base_comm_ok
);
    logic [3:0] ok_q;
    // A missing base never answers, so its link is never healthy
    always_ff @(posedge clk) begin
        base_present <= present_cfg;
        ok_q         <= present_cfg & ~drop;
        base_comm_ok <= slow ? ok_q : (present_cfg & ~drop);
    end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the expansion hold controller
`timescale 1ns/1ps
module tb_top
    import exp_hold_pkg::*;
;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, run_mode, irq, slow, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, out_image, module_out, r, img;
    logic [3:0]  base_present, base_comm_ok, pres, drop;
    logic [7:0]  base_addr_map;
    logic [15:0] h12, h34;
    integer      seed, fails, checked, k;

    exp_hold_ctrl i_exp_hold_ctrl (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .base_present(base_present), .base_comm_ok(base_comm_ok),
        .out_image(out_image), .module_out(module_out), .base_addr_map(base_addr_map),
        .run_mode(run_mode), .irq(irq));
    exp_base_model i_exp_base_model (.clk(clk), .present_cfg(pres), .drop(drop), .slow(slow),
        .base_present(base_present), .base_comm_ok(base_comm_ok));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Held bits of a failed base keep the image, the rest go off
    function automatic logic [7:0] fail_out(input logic [31:0] im, input int b);
        logic [31:0] m;
        m = {h34, h12};
        return im[b*8+:8] & m[b*8+:8];
    endfunction

    // Auto address index is the count of present bases below
    function automatic logic [7:0] auto_map(input logic [3:0] p);
        logic [7:0] m;
        logic [1:0] n;
        m = 8'h00;
        n = 2'd0;
        for (int b = 0; b < 4; b++) begin
            if (p[b]) begin
                m[b*2+:2] = n;
                n++;
            end
        end
        return m;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No bound of its own: a hang is ended by the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input logic [3:0] p);
        @(posedge clk);
        resetn <= 1'b0;
        pres <= p;
        drop <= 4'h0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        cyc(3);
    endtask

    task automatic complete_run;
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run;
    end

    initial begin
        seed = 76;
        fails = 0;
        checked = 0;
        {resetn, psel, penable, pwrite, slow} = 5'b00000;
        paddr = 12'h000;
        pwdata = 32'h0;
        out_image = 32'h0;
        pres = 4'hf;
        drop = 4'h0;
        do_reset(4'hf);
        apb(0, OFF_HOLD12, 0);
        chk(r, 32'h0);
        apb(0, 12'hffc, 0);
        chk({31'h0, e}, 32'h1);
        for (int t = 0; t < 4; t++) begin
            k = $unsigned($random(seed)) % 4;
            // Stimulus moves only on a rising edge
            @(posedge clk);
            slow <= t[0];
            r = $random(seed);
            h12 = r[15:0];
            r = $random(seed);
            h34 = r[15:0];
            apb(1, OFF_HOLD12, {16'hffff, h12});
            apb(1, OFF_HOLD34, {16'hffff, h34});
            apb(0, OFF_HOLD12, 0);
            chk(r, {16'h0, h12});
            apb(0, OFF_HOLD34, 0);
            chk(r, {16'h0, h34});
            apb(1, OFF_INT_MASK, 32'h3);
            apb(1, OFF_CTRL, 32'h9);
            img = $random(seed);
            out_image <= img;
            cyc(4);
            chk({31'h0, run_mode}, 32'h1);
            chk(module_out, img);
            @(posedge clk);
            drop[k] <= 1'b1;
            cyc(4);
            chk({31'h0, run_mode}, 32'h0);
            chk({24'h0, module_out[k*8+:8]}, {24'h0, fail_out(img, k)});
            chk({24'h0, module_out[((k + 1) % 4)*8+:8]}, {24'h0, img[((k + 1) % 4)*8+:8]});
            chk({31'h0, irq}, 32'h1);
            apb(0, OFF_INT_STAT, 0);
            chk(r, 32'h1);
            drop <= 4'h0;
            apb(1, OFF_INT_STAT, 32'h3);
            cyc(3);
            chk({31'h0, irq}, 32'h0);
        end
        do_reset(4'b1011);
        apb(1, OFF_CTRL, 32'h7);
        cyc(4);
        chk({31'h0, run_mode}, 32'h0);
        chk({24'h0, base_addr_map}, {24'h0, MAN_MAP_RESET});
        apb(0, OFF_ADDR_MAP, 0);
        chk(r, {24'h0, MAN_MAP_RESET});
        apb(0, OFF_INT_STAT, 0);
        chk(r, 32'h2);
        apb(0, OFF_STATUS, 0);
        chk(r, (32'h1 << ST_PWRUP_BIT) | (32'hb << ST_PRES_LSB));
        apb(1, OFF_CTRL, 32'h1);
        cyc(4);
        chk({31'h0, run_mode}, 32'h1);
        chk({24'h0, base_addr_map & 8'hcf}, {24'h0, auto_map(4'b1011)});
        complete_run;
    end
endmodule
